/* File: design/swk_cfg_regs.v */
// Selective wake configuration register bank with write/read port
`include "swk_consts.vh"
module swk_cfg_regs (
    input  wire                   MCLK,
    input  wire                   RST,
    input  wire                   REG_WR,
    input  wire                   REG_RD,
    input  wire [`SWK_ADDR_W-1:0] REG_ADDR,
    input  wire [15:0]            REG_WDATA,
    output reg  [15:0]            REG_RDATA,
    output reg                    REG_RVALID,
    input  wire                   WAKE_EVENT,
    input  wire                   CAN_TIMEOUT_EVENT,
    input  wire                   CAN_TIMEOUT_CLEAR,
    input  wire [`SWK_MODE_W-1:0] DEVICE_MODE,
    input  wire                   CAN_TRANSMIT_INPUT_PIN,
    output reg                    SELECTIVE_WAKE_ENABLED,
    output reg                    OSC_CALIBRATION_ACTIVE,
    output reg                    TRIM_PATTERN,
    output reg                    CAN_TIMEOUT_FLAG,
    output reg                    CAN_TIMEOUT_IRQ,
    output reg  [5:0]             SAMPLE_POINT_FRACTION,
    output reg  [7:0]             QUANTA_PER_BIT,
    output reg  [28:0]            WAKE_ID,
    output reg  [28:0]            WAKE_ID_COMPARE_MASK,
    output reg                    WAKE_ID_EXTENDED
);

    // ==========================================================
    // Intent and limitations
    // - Power-on and soft reset both arrive on RST. The partial
    //   retention of a restart is not modelled, so every field
    //   returns to its reset value on any reset.
    // - The lower identifier and both mask registers are held here
    //   only so that the frame decoder sees a whole identifier and
    //   mask. Their own behaviour lives with the decoder.
    // - Derived outputs lag the register file by one edge. This
    //   costs a cycle but keeps every top-level output a plain
    //   flip-flop, with no decode glitches at the pins.
    // - Writing a register with the value it already holds is not
    //   a change, so a repeated validate write keeps wake enabled.
    // - A write and a read in the same cycle are both taken; the
    //   read returns the value from before the write.
    // - The controller owns the trim pattern on the transmit pin;
    //   this block only gates it while calibration is enabled and unlocked.
    // - The write strobe is trusted for one cycle only: a strobe
    //   held high is taken again at every edge.

    // ==========================================================
    // Address decode shared by write strobes
    function sel;
        input [`SWK_ADDR_W-1:0] a;
        input [`SWK_ADDR_W-1:0] target;
        begin
            sel = (a == target);
        end
    endfunction

    wire wr_ctrl = REG_WR && sel(REG_ADDR, `SWK_ADDR_CTRL);

    // ==========================================================
    // Configuration registers other than control
    // Slot map of the generated registers:
    //   0 bit timing, 1 upper identifier, 2 lower identifier,
    //   3 upper mask, 4 lower mask
    localparam NREG = 5;
    wire [16*NREG-1:0] reg_vals;
    wire [NREG-1:0]    reg_chg;
    wire [`SWK_ADDR_W*NREG-1:0] reg_addrs = {`SWK_ADDR_MASK_LOWER,
        `SWK_ADDR_MASK_UPPER, `SWK_ADDR_ID_LOWER, `SWK_ADDR_ID_UPPER,
        `SWK_ADDR_TIMING};
    // Per-slot reset values and write masks, highest slot first
    localparam [16*NREG-1:0] REG_RST = {`SWK_RST_ID, `SWK_RST_ID,
        `SWK_RST_ID, `SWK_RST_ID, `SWK_RST_TIMING};
    localparam [16*NREG-1:0] REG_WM = {`SWK_WMASK_FULL, `SWK_WMASK_FULL,
        `SWK_WMASK_ID_LOWER, `SWK_WMASK_FULL, `SWK_WMASK_TIMING};

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
            // Timing keeps reserved 9:8 zero, lower id keeps bit 7 zero
            swk_reg16 #(
                .RST_VAL (REG_RST[16*gi +: 16]),
                .WMASK   (REG_WM[16*gi +: 16])
            ) u_reg (
                .clk     (MCLK),
                .rst     (RST),
                .wr_en   (REG_WR && sel(REG_ADDR,
                          reg_addrs[`SWK_ADDR_W*gi +: `SWK_ADDR_W])),
                .wr_data (REG_WDATA),
                .value_q (reg_vals[16*gi +: 16]),
                .changes (reg_chg[gi])
            );
        end
    endgenerate

    wire [15:0] timing_q     = reg_vals[15:0];
    wire [15:0] id_upper_q   = reg_vals[31:16];
    wire [15:0] id_lower_q   = reg_vals[47:32];
    wire [15:0] mask_upper_q = reg_vals[63:48];
    wire [15:0] mask_lower_q = reg_vals[79:64];

    // ==========================================================
    // Control register fields
    reg        valid_q;
    reg        to_mask_q;
    reg  [1:0] unlock_q;
    reg        osc_calibration_enable_q;

    // Any alteration of control bits other than the valid flag is a change
    wire ctrl_cfg_chg = wr_ctrl && (
        (REG_WDATA[`SELECTIVE_WAKE_CONTROL_TO_MASK] != to_mask_q) ||
        (REG_WDATA[`SELECTIVE_WAKE_CONTROL_UNLK_HI:`SELECTIVE_WAKE_CONTROL_UNLK_LO] != unlock_q) ||
        (REG_WDATA[`SELECTIVE_WAKE_CONTROL_OSC_CALIBRATION_ENABLE] != osc_calibration_enable_q));
    wire cfg_changed = ctrl_cfg_chg || (|reg_chg);

    // Control fields other than the valid flag
    always @(posedge MCLK) begin
        if (RST) begin
            to_mask_q <= 1'b0;
            unlock_q  <= 2'h0;
            osc_calibration_enable_q <= 1'b0;
        end else if (wr_ctrl) begin
            to_mask_q <= REG_WDATA[`SELECTIVE_WAKE_CONTROL_TO_MASK];
            unlock_q  <= REG_WDATA[`SELECTIVE_WAKE_CONTROL_UNLK_HI:`SELECTIVE_WAKE_CONTROL_UNLK_LO];
            osc_calibration_enable_q <= REG_WDATA[`SELECTIVE_WAKE_CONTROL_OSC_CALIBRATION_ENABLE];
        end
    end

    // Valid flag: hardware clear beats a software set in the same cycle,
    // since a set together with an edit would validate unchecked data
    always @(posedge MCLK) begin
        if (RST) begin
            valid_q <= 1'b0;
        end else if (WAKE_EVENT || cfg_changed) begin
            valid_q <= 1'b0;
        end else if (wr_ctrl) begin
            valid_q <= REG_WDATA[`SELECTIVE_WAKE_CONTROL_VALID];
        end
    end

    wire [15:0] ctrl_read = {8'h00, osc_calibration_enable_q, unlock_q, to_mask_q, 3'h0,
                             valid_q};

    // ==========================================================
    // Read mux: unmapped addresses read zero
    reg [15:0] rdata_d;
    always @* begin
        case (REG_ADDR)
            `SWK_ADDR_CTRL:       rdata_d = ctrl_read;
            `SWK_ADDR_TIMING:     rdata_d = timing_q;
            `SWK_ADDR_ID_UPPER:   rdata_d = id_upper_q;
            `SWK_ADDR_ID_LOWER:   rdata_d = id_lower_q;
            `SWK_ADDR_MASK_UPPER: rdata_d = mask_upper_q;
            `SWK_ADDR_MASK_LOWER: rdata_d = mask_lower_q;
            default:              rdata_d = 16'h0000;
        endcase
    end

    // Read port: one cycle latency; data holds until the next read,
    // so a slow controller may still pick it up later
    always @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA  <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_d;
            end
        end
    end

    // ==========================================================
    // Time-out flag and interrupt
    wire mode_ok = (DEVICE_MODE == `SWK_MODE_NORMAL) ||
                   (DEVICE_MODE == `SWK_MODE_STOP);
    wire unlocked = (unlock_q == `SWK_UNLOCK_CODE);

    // Status flag: set wins over a clear in the same cycle, and both
    // are ignored while wake is off, so stale bus events leave no trace
    always @(posedge MCLK) begin
        if (RST) begin
            CAN_TIMEOUT_FLAG <= 1'b0;
        end else if (SELECTIVE_WAKE_ENABLED) begin
            if (CAN_TIMEOUT_EVENT) begin
                CAN_TIMEOUT_FLAG <= 1'b1;
            end else if (CAN_TIMEOUT_CLEAR) begin
                CAN_TIMEOUT_FLAG <= 1'b0;
            end
        end
    end

    // Interrupt: one-cycle pulse per time-out event in normal or stop mode; a masked event
    // still sets the flag, so polling can find it
    always @(posedge MCLK) begin
        if (RST) begin
            CAN_TIMEOUT_IRQ <= 1'b0;
        end else begin
            CAN_TIMEOUT_IRQ <= CAN_TIMEOUT_EVENT && SELECTIVE_WAKE_ENABLED
                               && mode_ok
                               && to_mask_q;
        end
    end

    // ==========================================================
    // Wake enable: only on validated configuration; it drops in the same edge
    // as a wake or change clear of the valid flag, one edge after a software clear
    always @(posedge MCLK) begin
        if (RST) begin
            SELECTIVE_WAKE_ENABLED <= 1'b0;
        end else begin
            SELECTIVE_WAKE_ENABLED <= valid_q && !(WAKE_EVENT ||
                                      cfg_changed);
        end
    end

    // ==========================================================
    // Calibration runs only when both enabled and unlocked, so a
    // stray write of the enable bit alone cannot retune the clock
    always @(posedge MCLK) begin
        if (RST) begin
            OSC_CALIBRATION_ACTIVE <= 1'b0;
            TRIM_PATTERN           <= 1'b0;
        end else begin
            OSC_CALIBRATION_ACTIVE <= osc_calibration_enable_q && unlocked;
            // Pattern on the transmit pin passes only during calibration
            TRIM_PATTERN <= osc_calibration_enable_q && unlocked
                            && CAN_TRANSMIT_INPUT_PIN;
        end
    end

    // ==========================================================
    // Bit timing fields for the frame decoder
    always @(posedge MCLK) begin
        if (RST) begin
            SAMPLE_POINT_FRACTION <= 6'h00;
            QUANTA_PER_BIT        <= 8'h00;
        end else begin
            SAMPLE_POINT_FRACTION <= timing_q[`SWK_SP_HI:`SWK_SP_LO];
            QUANTA_PER_BIT <= timing_q[`SWK_QB_HI:`SWK_QB_LO];
        end
    end

    // ==========================================================
    // Packs an upper and lower register pair into 29 identifier bits,
    // skipping the reserved bit and the two frame-type bits
    function [28:0] pack_id;
        input [15:0] upper;
        input [15:0] lower;
        begin
            pack_id = {upper, lower[15:8], lower[6:2]};
        end
    endfunction

    wire [28:0] id_full   = pack_id(id_upper_q, id_lower_q);
    wire [28:0] mask_full = pack_id(mask_upper_q, mask_lower_q);

    // Standard frames compare only the top 11 identifier bits; the
    // rest of the mask is forced off rather than left to stale
    // extended-mode settings
    always @(posedge MCLK) begin
        if (RST) begin
            WAKE_ID              <= 29'h00000000;
            WAKE_ID_COMPARE_MASK <= 29'h00000000;
            WAKE_ID_EXTENDED     <= 1'b0;
        end else begin
            WAKE_ID <= id_full;
            WAKE_ID_EXTENDED <= id_lower_q[`SWK_IDE_BIT];
            WAKE_ID_COMPARE_MASK <= id_lower_q[`SWK_IDE_BIT] ?
                mask_full : {mask_upper_q[15:5], 18'h00000};
        end
    end

endmodule // swk_cfg_regs

/* File: design/swk_consts.vh */
// Constants for the selective wake configuration register bank
`ifndef SWK_CONSTS_VH
`define SWK_CONSTS_VH

// ==========================================================
// Register addresses (7-bit register address field)
`define SWK_ADDR_W          7
`define SWK_ADDR_CTRL       7'h30
`define SWK_ADDR_TIMING     7'h31
`define SWK_ADDR_ID_UPPER   7'h32
`define SWK_ADDR_ID_LOWER   7'h33
`define SWK_ADDR_MASK_UPPER 7'h34
`define SWK_ADDR_MASK_LOWER 7'h35

// ==========================================================
// Reset values
`define SWK_RST_CTRL        16'h0000
`define SWK_RST_TIMING      16'hCC96
`define SWK_RST_ID          16'h0000

// ==========================================================
// Writable bit masks (reserved bits read as zero)
`define SWK_WMASK_CTRL      16'h00F1
`define SWK_WMASK_TIMING    16'hFCFF
`define SWK_WMASK_ID_LOWER  16'hFF7F
`define SWK_WMASK_FULL      16'hFFFF

// ==========================================================
// Control field positions
`define SELECTIVE_WAKE_CONTROL_VALID      0
`define SELECTIVE_WAKE_CONTROL_TO_MASK    4
`define SELECTIVE_WAKE_CONTROL_UNLK_HI    6
`define SELECTIVE_WAKE_CONTROL_UNLK_LO    5
`define SELECTIVE_WAKE_CONTROL_OSC_CALIBRATION_ENABLE    7
`define SWK_UNLOCK_CODE     2'h3

// ==========================================================
// Timing and identifier field positions
`define SWK_SP_HI           15
`define SWK_SP_LO           10
`define SWK_QB_HI           7
`define SWK_QB_LO           0
`define SWK_IDE_BIT         0

// ==========================================================
// Device modes
`define SWK_MODE_W          2
`define SWK_MODE_NORMAL     2'h0
`define SWK_MODE_STOP       2'h1
`define SWK_MODE_SLEEP      2'h2
`define SWK_MODE_OTHER      2'h3

`endif

/* File: design/swk_reg16.v */
// One 16-bit configuration register with write mask and change detect
module swk_reg16 #(
    parameter [15:0] RST_VAL = 16'h0000,
    parameter [15:0] WMASK   = 16'hFFFF
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    output reg  [15:0] value_q,
    output wire        changes
);

    // Only writable bits are stored; reserved bits stay zero
    wire [15:0] masked_d = wr_data & WMASK;

    // A write that alters the stored value counts as a change
    assign changes = wr_en && (masked_d != value_q);

    // ==========================================================
    // Storage
    always @(posedge clk) begin
        if (rst) begin
            value_q <= RST_VAL & WMASK;
        end else if (wr_en) begin
            value_q <= masked_d;
        end
    end

endmodule // swk_reg16

/* File: tb/swk_mcu.sv */
// Controller model that drives the trim pattern onto the transmit pin
module swk_mcu (
    input  wire logic clk,
    input  wire logic cal,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Pattern source
    // Toggle while calibrating; idle high, as a recessive bus rests.
    // Calibration is off through reset, so the first edge sets it high
    always @(negedge clk) begin
        pin <= cal ? ~pin : 1'b1;
    end
endmodule // swk_mcu

/* File: tb/swk_chk.sv */
// Concurrent checks on the register bank ports
`include "swk_consts.vh"
module swk_chk (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [6:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_RVALID,
    input wire logic        WAKE_EVENT,
    input wire logic        CAN_TIMEOUT_EVENT,
    input wire logic [1:0]  DEVICE_MODE,
    input wire logic        CAN_TRANSMIT_INPUT_PIN,
    input wire logic        SELECTIVE_WAKE_ENABLED,
    input wire logic        OSC_CALIBRATION_ACTIVE,
    input wire logic        TRIM_PATTERN,
    input wire logic        CAN_TIMEOUT_FLAG,
    input wire logic        CAN_TIMEOUT_IRQ,
    input wire logic [5:0]  SAMPLE_POINT_FRACTION,
    input wire logic [7:0]  QUANTA_PER_BIT,
    input wire logic [28:0] WAKE_ID
);
    // ==========================================================
    // Properties
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Write strobe aimed at one register
    sequence s_wr(a);
        REG_WR && REG_ADDR == a;
    endsequence
    // Enable is judged over two samples: the flag may follow either edge
    sequence s_en_off;
        !SELECTIVE_WAKE_ENABLED ##1 !SELECTIVE_WAKE_ENABLED;
    endsequence
    a_rd_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    a_unmapped_zero: assert property (REG_RD &&
        REG_ADDR > `SWK_ADDR_MASK_LOWER |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_en_needs_wr: assert property ($rose(SELECTIVE_WAKE_ENABLED) |->
        $past(REG_WR, 2) && ($past(REG_WDATA, 2) & 16'h0001) != 0)
        else $error("enable without valid write");
    a_wake_clear: assert property (WAKE_EVENT |=> ##1
        !SELECTIVE_WAKE_ENABLED) else $error("wake kept enable");
    a_irq_cause: assert property (CAN_TIMEOUT_IRQ |->
        $past(CAN_TIMEOUT_EVENT) && $past(DEVICE_MODE) < `SWK_MODE_SLEEP)
        else $error("irq without cause");
    a_flag_hold: assert property (s_en_off |->
        $stable(CAN_TIMEOUT_FLAG)) else $error("flag moved while off");
    a_flag_set: assert property (CAN_TIMEOUT_EVENT &&
        SELECTIVE_WAKE_ENABLED ##1 SELECTIVE_WAKE_ENABLED |->
        CAN_TIMEOUT_FLAG) else $error("flag not set");
    a_trim_follow: assert property (OSC_CALIBRATION_ACTIVE &&
        $past(OSC_CALIBRATION_ACTIVE) |->
        TRIM_PATTERN == $past(CAN_TRANSMIT_INPUT_PIN))
        else $error("trim not following pin");
    a_timing_load: assert property (s_wr(`SWK_ADDR_TIMING) |=> ##1
        {SAMPLE_POINT_FRACTION, 2'b00, QUANTA_PER_BIT} ==
        ($past(REG_WDATA, 2) & 16'hFCFF)) else $error("timing fields");
    a_id_upper: assert property (s_wr(`SWK_ADDR_ID_UPPER) |=> ##1
        WAKE_ID[28:13] == $past(REG_WDATA, 2)) else $error("id upper");
endmodule // swk_chk

/* File: tb/tb.sv */
// Self-checking bench for the selective wake register bank
`include "swk_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Stimulus and observed signals
    logic        clk = 0, rst = 1, w = 0, r = 0, wake = 0;
    logic        ev = 0, clr = 0, pin, swe, osc, trim, flag, irq, ext;
    logic [6:0]  addr = 0;
    logic [15:0] wdata = 0, rdata;
    logic        rvalid;
    logic [1:0]  mode = 0;
    logic [5:0]  sp;
    logic [7:0]  qpb;
    logic [28:0] wid, wmask;
    int          n_mismatch = 0, num_checks = 0, cycles = 0;
    swk_cfg_regs dut (.MCLK(clk), .RST(rst), .REG_WR(w), .REG_RD(r),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .WAKE_EVENT(wake), .CAN_TIMEOUT_EVENT(ev),
        .CAN_TIMEOUT_CLEAR(clr), .DEVICE_MODE(mode),
        .CAN_TRANSMIT_INPUT_PIN(pin), .SELECTIVE_WAKE_ENABLED(swe),
        .OSC_CALIBRATION_ACTIVE(osc), .TRIM_PATTERN(trim),
        .CAN_TIMEOUT_FLAG(flag), .CAN_TIMEOUT_IRQ(irq),
        .SAMPLE_POINT_FRACTION(sp), .QUANTA_PER_BIT(qpb), .WAKE_ID(wid),
        .WAKE_ID_COMPARE_MASK(wmask), .WAKE_ID_EXTENDED(ext));
    swk_mcu mcu (.clk(clk), .cal(osc), .pin(pin));
    initial forever #10 clk = ~clk;
    // ==========================================================
    // Tasks; all start and end at a falling edge
    task automatic chk(input logic [28:0] seen, input logic [28:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wreg(input logic [6:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        w = 1;
        cyc(1);
        w = 0;
    endtask
    task automatic rreg(input logic [6:0] a, input logic [15:0] e);
        addr = a;
        r = 1;
        cyc(1);
        r = 0;
        chk(rvalid, 1);
        chk(rdata, e);
        cyc(1);
    endtask
    // Time-out pulse, then the interrupt seen one cycle on
    task automatic tout(input logic e);
        ev = 1;
        cyc(1);
        ev = 0;
        chk(irq, e);
        cyc(1);
    endtask
    task automatic summarize;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard; the sequence needs well under 300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        cyc(10);
        rst = 0;
        cyc(2);
        rreg(`SWK_ADDR_CTRL, 16'h0000);
        rreg(`SWK_ADDR_TIMING, 16'hCC96);
        rreg(`SWK_ADDR_ID_UPPER, 16'h0000);
        chk(sp, 6'h33);
        wreg(`SWK_ADDR_CTRL, 16'h0001);
        cyc(1);
        chk(swe, 1);
        tout(0);
        chk(flag, 1);
        clr = 1;
        cyc(1);
        clr = 0;
        chk(flag, 0);
        wreg(`SWK_ADDR_CTRL, 16'h0011);
        cyc(1);
        chk(swe, 0);
        rreg(`SWK_ADDR_CTRL, 16'h0010);
        wreg(`SWK_ADDR_CTRL, 16'h0011);
        cyc(1);
        chk(swe, 1);
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            tout(m < 2);
        end
        mode = 0;
        wake = 1;
        cyc(1);
        wake = 0;
        cyc(1);
        chk(swe, 0);
        clr = 1;
        cyc(1);
        clr = 0;
        chk(flag, 1);
        for (int u = 0; u < 4; u++) begin
            wreg(`SWK_ADDR_CTRL, {8'h00, 1'b1, u[1:0], 5'h00});
            cyc(1);
            chk(osc, u == 3);
            chk(trim, pin && u == 3);
        end
        repeat (4) begin
            cyc(1);
            chk(trim, pin);
        end
        wreg(`SWK_ADDR_CTRL, 16'h0060);
        cyc(1);
        chk(osc, 0);
        wreg(`SWK_ADDR_CTRL, 16'hFFFF);
        rreg(`SWK_ADDR_CTRL, 16'h00F0);
        wreg(`SWK_ADDR_TIMING, 16'hFFFF);
        rreg(`SWK_ADDR_TIMING, 16'hFCFF);
        chk(qpb, 8'hFF);
        wreg(`SWK_ADDR_ID_UPPER, 16'hA5C3);
        rreg(`SWK_ADDR_ID_UPPER, 16'hA5C3);
        chk(wid[28:13], 16'hA5C3);
        wreg(`SWK_ADDR_MASK_UPPER, 16'hFFFF);
        cyc(1);
        chk(wmask, {11'h7FF, 18'h0});
        wreg(`SWK_ADDR_ID_LOWER, 16'h0001);
        cyc(1);
        chk(ext, 1);
        chk(wmask, {16'hFFFF, 13'h0});
        rreg(7'h7F, 16'h0000);
        summarize;
    end
endmodule // tb
bind swk_cfg_regs swk_chk u_chk (
    .MCLK                   (MCLK),
    .RST                    (RST),
    .REG_WR                 (REG_WR),
    .REG_RD                 (REG_RD),
    .REG_ADDR               (REG_ADDR),
    .REG_WDATA              (REG_WDATA),
    .REG_RDATA              (REG_RDATA),
    .REG_RVALID             (REG_RVALID),
    .WAKE_EVENT             (WAKE_EVENT),
    .CAN_TIMEOUT_EVENT      (CAN_TIMEOUT_EVENT),
    .DEVICE_MODE            (DEVICE_MODE),
    .CAN_TRANSMIT_INPUT_PIN (CAN_TRANSMIT_INPUT_PIN),
    .SELECTIVE_WAKE_ENABLED (SELECTIVE_WAKE_ENABLED),
    .OSC_CALIBRATION_ACTIVE (OSC_CALIBRATION_ACTIVE),
    .TRIM_PATTERN           (TRIM_PATTERN),
    .CAN_TIMEOUT_FLAG       (CAN_TIMEOUT_FLAG),
    .CAN_TIMEOUT_IRQ        (CAN_TIMEOUT_IRQ),
    .SAMPLE_POINT_FRACTION  (SAMPLE_POINT_FRACTION),
    .QUANTA_PER_BIT         (QUANTA_PER_BIT),
    .WAKE_ID                (WAKE_ID)
);
